// *** logic/adcis_top.sv ***
// Operation
// - a pin set to analog input loses every other pin function
// - programmed pull-high on an analog pin is disconnected automatically
// - analog selection overrides the port direction setting
// - external group with channel 0 to 3 routes pins 0 to 3
// - external group with channel 4 to 15 connects nothing, input floats
// - source codes 1 to 4 pick bandgap, amp a, amp b, line amp
// - bandgap output enable bit, reset 0, else output high impedance
// - conversion is 4 sampling plus 12 converting clocks, 16 total
// - start bit pulsed low-high-low begins a conversion
// - busy high while converting, low when result registers are ready
// - power enable needed to convert; clearing it switches converter off
// - result is 12 bits, full scale fff
// - divider code 0 to 7 gives system clock over 1 to 128
// - completion sets interrupt flag and raises irq when enabled
`timescale 1ns/1ns
`default_nettype none

`include "adcis_consts.svh"

module adcis_top (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// apb slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic             o_pready,
	output logic [31:0]      o_prdata,
	output logic             o_pslverr,
	// shared pin control from the port logic
	input  wire logic [3:0]  i_pin_pull_high_en,
	input  wire logic [3:0]  i_pin_dir_out,
	input  wire logic [3:0]  i_pin_other_func_en,
	output logic [3:0]       o_pin_pull_high_en,
	output logic [3:0]       o_pin_dir_out,
	output logic [3:0]       o_pin_other_func_en,
	output logic [3:0]       o_pin_analog_sel,
	// analog multiplexer
	output logic [3:0]       o_mux_ext_connect,
	output logic             o_mux_bandgap,
	output logic             o_mux_amp_a,
	output logic             o_mux_amp_b,
	output logic             o_mux_line_amp,
	output logic             o_bandgap_out_en,
	output logic             o_ref_from_supply,
	// converter core
	input  wire logic [11:0] i_core_result,
	output logic             o_core_power,
	output logic             o_core_sample,
	output logic             o_core_convert,
	output logic             o_core_tick,
	output logic             o_converter_irq
);

	adcis_pkg::adcis_state_t r_reg;
	adcis_pkg::adcis_state_t r_next;

	logic        wr_en;
	logic        rd_setup;
	logic        start_fall;
	logic        div_clear;
	logic        tick;
	logic        ext_group;
	logic [7:0]  res_high;
	logic [7:0]  res_low;
	logic [7:0]  rd_byte;
	logic        rd_hit;

	////////////////////////////////////////////////////////////////////
	// bus handshake: zero wait states, read data caught in setup

	assign o_pready  = i_psel & i_penable;
	assign o_prdata  = r_reg.prdata;
	assign o_pslverr = r_reg.pslverr & i_psel & i_penable;
	assign wr_en     = i_psel & i_penable & i_pwrite;
	assign rd_setup  = i_psel & ~i_penable;

	// start is honoured on the falling half of the pulse
	assign start_fall = wr_en && (i_paddr == `ADCIS_OFS_CTL_FIRST)
		&& r_reg.start_bit && !i_pwdata[`ADCIS_BIT_START];

	////////////////////////////////////////////////////////////////////
	// result placement and read decode

	always_comb begin
		if (r_reg.fmt_sel) begin
			res_high = {4'h0, r_reg.result[11:8]};
			res_low  = r_reg.result[7:0];
		end else begin
			res_high = r_reg.result[11:4];
			res_low  = {r_reg.result[3:0], 4'h0};
		end
	end

	always_comb begin
		rd_hit  = 1'b1;
		rd_byte = 8'h00;
		if (i_paddr == `ADCIS_OFS_CTL_FIRST) begin
			rd_byte = {r_reg.start_bit, r_reg.busy, r_reg.power_en,
				r_reg.fmt_sel, r_reg.ext_sel};
		end else if (i_paddr == `ADCIS_OFS_CTL_SECOND) begin
			rd_byte = {r_reg.src_sel, r_reg.ref_sel, r_reg.div_sel};
		end else if (i_paddr == `ADCIS_OFS_RES_HIGH) begin
			rd_byte = res_high;
		end else if (i_paddr == `ADCIS_OFS_RES_LOW) begin
			rd_byte = res_low;
		end else if (i_paddr == `ADCIS_OFS_BANDGAP) begin
			rd_byte = {7'h00, r_reg.bandgap_en};
		end else if (i_paddr == `ADCIS_OFS_PIN_FUNC) begin
			rd_byte = {4'h0, r_reg.pin_analog};
		end else if (i_paddr == `ADCIS_OFS_INT_CTL) begin
			rd_byte = {5'h00, r_reg.cflag, r_reg.cie, r_reg.gie};
		end else begin
			rd_hit = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// registers and conversion sequencer

	always_comb begin
		r_next = r_reg;
		if (rd_setup) begin
			r_next.prdata  = {24'h000000, rd_byte};
			r_next.pslverr = ~rd_hit;
		end
		if (wr_en) begin
			if (i_paddr == `ADCIS_OFS_CTL_FIRST) begin
				r_next.start_bit = i_pwdata[`ADCIS_BIT_START];
				r_next.power_en  = i_pwdata[`ADCIS_BIT_POWER];
				r_next.fmt_sel   = i_pwdata[`ADCIS_BIT_FORMAT];
				r_next.ext_sel   = i_pwdata[3:0];
			end else if (i_paddr == `ADCIS_OFS_CTL_SECOND) begin
				r_next.src_sel = i_pwdata[`ADCIS_SRC_HI:`ADCIS_SRC_LO];
				r_next.ref_sel = i_pwdata[`ADCIS_REF_HI:`ADCIS_REF_LO];
				r_next.div_sel = i_pwdata[`ADCIS_DIV_HI:`ADCIS_DIV_LO];
			end else if (i_paddr == `ADCIS_OFS_BANDGAP) begin
				r_next.bandgap_en = i_pwdata[0];
			end else if (i_paddr == `ADCIS_OFS_PIN_FUNC) begin
				r_next.pin_analog = i_pwdata[3:0];
			end else if (i_paddr == `ADCIS_OFS_INT_CTL) begin
				r_next.gie   = i_pwdata[`ADCIS_BIT_GIE];
				r_next.cie   = i_pwdata[`ADCIS_BIT_CIE];
				r_next.cflag = i_pwdata[`ADCIS_BIT_CFLAG];
			end
		end
		// the sequencer comes last so a completion beats a flag clear
		if (!r_next.power_en) begin
			r_next.busy  = 1'b0;
			r_next.phase = adcis_pkg::ADCIS_IDLE;
			r_next.cnt   = 4'h0;
		end else if (start_fall) begin
			r_next.busy  = 1'b1;
			r_next.phase = adcis_pkg::ADCIS_SAMPLE;
			r_next.cnt   = 4'h0;
		end else if (tick) begin
			case (r_reg.phase)
				adcis_pkg::ADCIS_SAMPLE: begin
					if (r_reg.cnt == `ADCIS_SAMPLE_CYC - 4'h1) begin
						r_next.phase = adcis_pkg::ADCIS_CONVERT;
						r_next.cnt   = 4'h0;
					end else begin
						r_next.cnt = r_reg.cnt + 4'h1;
					end
				end
				adcis_pkg::ADCIS_CONVERT: begin
					if (r_reg.cnt == `ADCIS_CONVERT_CYC - 4'h1) begin
						r_next.phase  = adcis_pkg::ADCIS_IDLE;
						r_next.cnt    = 4'h0;
						r_next.busy   = 1'b0;
						r_next.result = i_core_result;
						r_next.cflag  = 1'b1;
					end else begin
						r_next.cnt = r_reg.cnt + 4'h1;
					end
				end
				default: begin
					r_next.cnt = 4'h0;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// converter clock; restarted with each conversion so phases align

	assign div_clear = start_fall || (r_reg.phase == adcis_pkg::ADCIS_IDLE);

	adcis_clk_div #(
		.DIV_W(7)
	) u_div (
		.i_clk    (i_clk),
		.i_rst    (i_rst),
		.i_div_sel(r_reg.div_sel),
		.i_clear  (div_clear),
		.o_tick   (tick)
	);

	////////////////////////////////////////////////////////////////////
	// input selection and shared pins

	// codes 0 and 5 to 7 all mean the external group
	assign ext_group = (r_reg.src_sel == `ADCIS_SRC_EXT) ||
		(r_reg.src_sel > `ADCIS_SRC_LINE);

	genvar g;
	generate
		for (g = 0; g < `ADCIS_PIN_COUNT; g++) begin : g_pin
			// channel codes 4 to 15 match no pin and leave the input open
			assign o_mux_ext_connect[g] = ext_group &&
				(r_reg.ext_sel == 4'(g));
			adcis_pin_ctl u_pin (
				.i_analog_sel   (r_reg.pin_analog[g]),
				.i_pull_high_en (i_pin_pull_high_en[g]),
				.i_dir_out      (i_pin_dir_out[g]),
				.i_other_func_en(i_pin_other_func_en[g]),
				.o_pull_high_en (o_pin_pull_high_en[g]),
				.o_dir_out      (o_pin_dir_out[g]),
				.o_other_func_en(o_pin_other_func_en[g])
			);
		end
	endgenerate

	// external channel is interlocked by the group decode: an internal source code drops every pin
	assign o_mux_bandgap  = (r_reg.src_sel == `ADCIS_SRC_BANDGAP);
	assign o_mux_amp_a    = (r_reg.src_sel == `ADCIS_SRC_AMP_A);
	assign o_mux_amp_b    = (r_reg.src_sel == `ADCIS_SRC_AMP_B);
	assign o_mux_line_amp = (r_reg.src_sel == `ADCIS_SRC_LINE);

	assign o_pin_analog_sel  = r_reg.pin_analog;
	assign o_bandgap_out_en  = r_reg.bandgap_en;
	assign o_ref_from_supply = (r_reg.ref_sel == `ADCIS_REF_SUPPLY);

	////////////////////////////////////////////////////////////////////
	// converter core strobes and interrupt

	assign o_core_power   = r_reg.power_en;
	assign o_core_sample  = (r_reg.phase == adcis_pkg::ADCIS_SAMPLE);
	assign o_core_convert = (r_reg.phase == adcis_pkg::ADCIS_CONVERT);
	assign o_core_tick    = tick & r_reg.busy;
	assign o_converter_irq = r_reg.cflag & r_reg.cie & r_reg.gie;

endmodule : adcis_top

`default_nettype wire

// *** logic/adcis_consts.svh ***
`ifndef ADCIS_CONSTS_SVH
`define ADCIS_CONSTS_SVH

// register byte addresses
`define ADCIS_OFS_CTL_FIRST   12'h000
`define ADCIS_OFS_CTL_SECOND  12'h004
`define ADCIS_OFS_RES_HIGH    12'h008
`define ADCIS_OFS_RES_LOW     12'h00c
`define ADCIS_OFS_BANDGAP     12'h010
`define ADCIS_OFS_PIN_FUNC    12'h014
`define ADCIS_OFS_INT_CTL     12'h018

// converter_control_first fields
`define ADCIS_BIT_START       7
`define ADCIS_BIT_BUSY        6
`define ADCIS_BIT_POWER       5
`define ADCIS_BIT_FORMAT      4
// converter_control_second fields
`define ADCIS_SRC_HI          7
`define ADCIS_SRC_LO          5
`define ADCIS_REF_HI          4
`define ADCIS_REF_LO          3
`define ADCIS_DIV_HI          2
`define ADCIS_DIV_LO          0
// interrupt control fields
`define ADCIS_BIT_GIE         0
`define ADCIS_BIT_CIE         1
`define ADCIS_BIT_CFLAG       2

// source group codes
`define ADCIS_SRC_EXT         3'h0
`define ADCIS_SRC_BANDGAP     3'h1
`define ADCIS_SRC_AMP_A       3'h2
`define ADCIS_SRC_AMP_B       3'h3
`define ADCIS_SRC_LINE        3'h4
`define ADCIS_REF_SUPPLY      2'h1

// converter clock counts per phase
`define ADCIS_SAMPLE_CYC      4'h4
`define ADCIS_CONVERT_CYC     4'hc
`define ADCIS_RESULT_W        12
`define ADCIS_PIN_COUNT       4

`endif

// *** logic/adcis_pkg.sv ***
`include "adcis_consts.svh"

package adcis_pkg;

	typedef enum logic [1:0] {
		ADCIS_IDLE    = 2'b00,
		ADCIS_SAMPLE  = 2'b01,
		ADCIS_CONVERT = 2'b10
	} adcis_phase_t;

	typedef struct packed {
		logic [3:0]                 ext_sel;
		logic                       start_bit;
		logic                       power_en;
		logic                       fmt_sel;
		logic [2:0]                 src_sel;
		logic [1:0]                 ref_sel;
		logic [2:0]                 div_sel;
		logic                       bandgap_en;
		logic [3:0]                 pin_analog;
		logic                       gie;
		logic                       cie;
		logic                       cflag;
		logic                       busy;
		adcis_phase_t               phase;
		logic [3:0]                 cnt;
		logic [`ADCIS_RESULT_W-1:0] result;
		logic [31:0]                prdata;
		logic                       pslverr;
	} adcis_state_t;

	typedef struct packed {
		logic [6:0] cnt;
	} adcis_div_state_t;

endpackage : adcis_pkg

// *** logic/adcis_clk_div.sv ***
`timescale 1ns/1ns
`default_nettype none

module adcis_clk_div #(
	parameter int DIV_W = 7
) (
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic [2:0] i_div_sel,
	input  wire logic       i_clear,
	output logic            o_tick
);

	adcis_pkg::adcis_div_state_t r_reg;
	adcis_pkg::adcis_div_state_t r_next;
	logic [DIV_W-1:0]            limit;

	// code n divides the system clock by two to the n
	assign limit  = DIV_W'((8'h01 << i_div_sel) - 8'h01);
	assign o_tick = (r_reg.cnt == limit);

	always_comb begin
		r_next = r_reg;
		if (i_clear || o_tick) begin
			r_next.cnt = '0;
		end else begin
			r_next.cnt = r_reg.cnt + 7'h01;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

endmodule : adcis_clk_div

`default_nettype wire

// *** logic/adcis_pin_ctl.sv ***
`timescale 1ns/1ns
`default_nettype none

module adcis_pin_ctl (
	input  wire logic i_analog_sel,
	input  wire logic i_pull_high_en,
	input  wire logic i_dir_out,
	input  wire logic i_other_func_en,
	output logic      o_pull_high_en,
	output logic      o_dir_out,
	output logic      o_other_func_en
);

	// an analog pin keeps nothing of its digital set-up
	assign o_other_func_en = i_other_func_en & ~i_analog_sel;
	assign o_pull_high_en  = i_pull_high_en & ~i_analog_sel;
	assign o_dir_out       = i_dir_out & ~i_analog_sel;

endmodule : adcis_pin_ctl

`default_nettype wire

// *** test/adcis_core_model.sv ***
`timescale 1ns/1ns
`default_nettype none

module adcis_core_model #(
	parameter logic [11:0] VAL = 12'hfff
) (
	input  wire logic        i_clk,
	input  wire logic        i_convert,
	output logic      [11:0] o_result
);
	logic [11:0] junk = 12'h555;
	// no stale value outside conversion: a late sample must show
	always_ff @(posedge i_clk) junk <= ~junk;
	assign o_result = i_convert ? VAL : junk;
endmodule : adcis_core_model

`default_nettype wire

// *** test/adcis_top_props.sv ***
`timescale 1ns/1ns
`default_nettype none

module adcis_top_props (
	input wire logic       i_clk,
	input wire logic       i_rst,
	input wire logic       i_psel,
	input wire logic       i_penable,
	input wire logic       o_pready,
	input wire logic       o_pslverr,
	input wire logic [3:0] i_pin_other_func_en,
	input wire logic [3:0] o_pin_other_func_en,
	input wire logic [3:0] o_pin_analog_sel,
	input wire logic [3:0] o_mux_ext_connect,
	input wire logic       o_mux_bandgap,
	input wire logic       o_mux_amp_a,
	input wire logic       o_mux_amp_b,
	input wire logic       o_mux_line_amp,
	input wire logic       o_core_power,
	input wire logic       o_core_sample,
	input wire logic       o_core_convert
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence s_conv_on; o_core_convert && !o_core_sample; endsequence
	property p_ready; o_pready == (i_psel && i_penable); endproperty
	property p_slverr; o_pslverr |-> i_psel && i_penable; endproperty
	property p_pin; o_pin_other_func_en ==
		(i_pin_other_func_en & ~o_pin_analog_sel); endproperty
	property p_ext; $onehot0(o_mux_ext_connect); endproperty
	property p_int; $onehot0({o_mux_bandgap, o_mux_amp_a,
		o_mux_amp_b, o_mux_line_amp}); endproperty
	property p_off; !o_core_power |-> !o_core_sample && !o_core_convert;
	endproperty
	property p_order; $fell(o_core_sample) && o_core_power |-> s_conv_on;
	endproperty
	property p_after; $rose(o_core_convert) |-> $past(o_core_sample);
	endproperty
	a_ready: assert property (p_ready)
		else $error("pready wrong");
	a_slverr: assert property (p_slverr)
		else $error("pslverr outside access");
	a_pin: assert property (p_pin)
		else $error("pin function kept");
	a_ext: assert property (p_ext)
		else $error("two pins routed");
	a_int: assert property (p_int)
		else $error("two sources routed");
	a_off: assert property (p_off)
		else $error("active while off");
	a_order: assert property (p_order)
		else $error("sampling not followed by conversion");
	a_after: assert property (p_after)
		else $error("conversion without sampling");
endmodule : adcis_top_props

bind adcis_top adcis_top_props u_props (.*);

`default_nettype wire

// *** test/tb_adc_input_select_and_sequencer.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "adcis_consts.svh"

module tb_adc_input_select_and_sequencer;
	logic        i_clk, i_rst, i_psel, i_penable, i_pwrite, er;
	logic        o_pready, o_pslverr, o_bandgap_out_en, o_ref_from_supply;
	logic        o_mux_bandgap, o_mux_amp_a, o_mux_amp_b, o_mux_line_amp;
	logic        o_core_power, o_core_sample, o_core_convert;
	logic        o_core_tick, o_converter_irq;
	logic [11:0] i_paddr, i_core_result;
	logic [31:0] i_pwdata, o_prdata, rd;
	logic [3:0]  i_pin_pull_high_en, i_pin_dir_out, i_pin_other_func_en;
	logic [3:0]  o_pin_pull_high_en, o_pin_dir_out, o_pin_other_func_en;
	logic [3:0]  o_pin_analog_sel, o_mux_ext_connect;
	int          n_errors = 0;
	int          compares = 0;
	localparam logic [11:0] RES = 12'ha5c;
	localparam logic [11:0] F1 = `ADCIS_OFS_CTL_FIRST;
	localparam logic [11:0] F2 = `ADCIS_OFS_CTL_SECOND;
	localparam logic [11:0] IC = `ADCIS_OFS_INT_CTL;

	adcis_top dut (.*);
	adcis_core_model #(.VAL(RES)) u_core (.i_clk, .i_convert(o_core_convert),
		.o_result(i_core_result));

	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			n_errors++;
			$display("ERROR %0t: got %h want %h", $time, s, e);
		end
	endtask : chk

	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [7:0] d);
		int n;
		@(posedge i_clk);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= {24'h0, d};
		@(posedge i_clk);
		i_penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_pready !== 1'b1 && n < 50);
		rd = o_prdata;
		er = o_pslverr;
		if (n >= 50) n_errors++;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask : xfer

	// divider code d also picks format and irq enables, covering both
	task automatic conv(input logic [2:0] d, input logic rs);
		int n, nt, ns;
		xfer(1, F2, {5'h01, d});
		xfer(1, F1, {3'h1, d[0], 4'h1});
		// core settling time after power-up, before any start pulse
		repeat (8) @(posedge i_clk);
		xfer(1, IC, {6'h0, d[0], d[0]});
		for (int i = 0; i <= rs; i++) begin
			if (i > 0) repeat (20) @(posedge i_clk);
			xfer(1, F1, {3'h5, d[0], 4'h1});
			xfer(1, F1, {3'h1, d[0], 4'h1});
		end
		#1;
		n = 0;
		nt = 0;
		ns = 0;
		while ((o_core_sample | o_core_convert) === 1'b1 && n < 3000) begin
			nt += o_core_tick;
			ns += o_core_sample;
			@(posedge i_clk);
			#1;
			n++;
		end
		chk(n, 32'd16 << d);
		chk(nt, 16);
		chk(ns, 32'd4 << d);
		chk(o_converter_irq, d[0]);
		chk(o_ref_from_supply, 1);
		xfer(0, F1, 0);
		chk(rd, {27'h1, d[0], 4'h1});
		xfer(0, `ADCIS_OFS_RES_HIGH, 0);
		chk(rd, d[0] ? RES[11:8] : RES[11:4]);
		xfer(0, `ADCIS_OFS_RES_LOW, 0);
		chk(rd, d[0] ? RES[7:0] : {RES[3:0], 4'h0});
		xfer(0, IC, 0);
		chk(rd, {d[0], d[0]} | 32'h4);
	endtask : conv

	task automatic conclude;
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude

	initial begin
		{i_rst, i_psel, i_penable, i_pwrite} = 4'h8;
		i_paddr = 12'h000;
		i_pwdata = 32'h0;
		{i_pin_pull_high_en, i_pin_dir_out, i_pin_other_func_en} = 12'hfff;
		repeat (12) @(posedge i_clk);
		i_rst <= 1'b0;
		for (int a = 0; a < 8; a++) begin
			xfer(0, 12'(a * 4), 0);
			chk(rd, 0);
			chk(er, a == 7);
		end
		xfer(1, `ADCIS_OFS_BANDGAP, 8'hff);
		xfer(0, `ADCIS_OFS_BANDGAP, 0);
		chk(rd, 1);
		chk(o_bandgap_out_en, 1);
		xfer(1, `ADCIS_OFS_PIN_FUNC, 8'h05);
		#1;
		chk(o_pin_other_func_en, 4'ha);
		chk(o_pin_pull_high_en, 4'ha);
		chk(o_pin_dir_out, 4'ha);
		chk(o_pin_analog_sel, 4'h5);
		$display("registers and pins done");
		for (int c = 0; c < 16; c++) begin
			// source codes 0 and 5 to 7 all belong to the external group
			xfer(1, F2, {(c[1:0] == 2'h0) ? 3'h0 : 3'(c[1:0] + 4), 5'h00});
			xfer(1, F1, 8'(c));
			#1;
			chk(o_mux_ext_connect, c < 4 ? 4'(1 << c) : 4'h0);
		end
		for (int s = 1; s < 5; s++) begin
			// channel left parked at 15 by the loop above
			xfer(1, F2, {s[2:0], 5'h0});
			#1;
			chk(o_mux_ext_connect, 4'h0);
			chk(o_ref_from_supply, 0);
			chk({o_mux_bandgap, o_mux_amp_a, o_mux_amp_b, o_mux_line_amp},
				4'h8 >> (s - 1));
		end
		$display("routing done");
		for (int d = 0; d < 8; d++) conv(3'(d), 1'b0);
		conv(3'h2, 1'b1);
		$display("conversions done");
		xfer(1, F1, 8'ha0);
		xfer(1, F1, 8'h20);
		repeat (10) @(posedge i_clk);
		xfer(1, F1, 8'h00);
		#1;
		chk(o_core_sample | o_core_convert | o_core_power, 0);
		xfer(1, F1, 8'h80);
		xfer(1, F1, 8'h00);
		xfer(0, F1, 0);
		chk(rd, 0);
		$display("power off done");
		conclude();
	end

	initial begin
		#400000;
		n_errors++;
		conclude();
	end
endmodule : tb_adc_input_select_and_sequencer

`default_nettype wire
